//--- hw/interrupt_flag_status_bank.sv
// Interrupt flag status bank with enables, APB register access and one interrupt line.
//
// Added by the designer: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module interrupt_flag_status_bank
  import irq_flag_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] src_req_0,
  input wire logic [15:0] src_req_1,
  input wire logic [15:0] src_req_2,
  output logic [15:0] irq_flags_0,
  output logic [15:0] irq_flags_1,
  output logic [15:0] irq_flags_2,
  output logic [15:0] pending_0,
  output logic [15:0] pending_1,
  output logic [15:0] pending_2,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave: one wait state, read data and error are registered.

  logic ack;
  logic next_ack;
  logic [31:0] next_prdata;
  logic bad;
  logic next_bad;
  logic access;
  logic hit_flags_0;
  logic hit_flags_1;
  logic hit_flags_2;
  logic hit_enable_0;
  logic hit_enable_1;
  logic hit_enable_2;
  logic mapped;
  logic wr_done;
  logic [15:0] enable_0;
  logic [15:0] enable_1;
  logic [15:0] enable_2;

  assign access = psel && penable;
  assign hit_flags_0 = (paddr == OFF_IRQ_FLAGS_0);
  assign hit_flags_1 = (paddr == OFF_IRQ_FLAGS_1);
  assign hit_flags_2 = (paddr == OFF_IRQ_FLAGS_2);
  assign hit_enable_0 = (paddr == OFF_IRQ_ENABLE_0);
  assign hit_enable_1 = (paddr == OFF_IRQ_ENABLE_1);
  assign hit_enable_2 = (paddr == OFF_IRQ_ENABLE_2);
  assign mapped = hit_flags_0 || hit_flags_1 || hit_flags_2 || hit_enable_0 || hit_enable_1 || hit_enable_2;
  assign pready = access && ack;
  assign pslverr = pready && bad;
  // A write lands only at the edge that completes the transfer.
  assign wr_done = pready && pwrite && mapped;

  always_comb begin
    next_ack = access && !ack;
    next_bad = bad;
    next_prdata = prdata;
    if (access && !ack) begin
      next_bad = !mapped;
      next_prdata = 32'h0000_0000;
      if (!pwrite) begin
        // Reserved bits and the upper half word read as zero.
        if (hit_flags_0) begin
          next_prdata = {16'h0000, irq_flags_0};
        end else if (hit_flags_1) begin
          next_prdata = {16'h0000, irq_flags_1};
        end else if (hit_flags_2) begin
          next_prdata = {16'h0000, irq_flags_2};
        end else if (hit_enable_0) begin
          next_prdata = {16'h0000, enable_0};
        end else if (hit_enable_1) begin
          next_prdata = {16'h0000, enable_1};
        end else if (hit_enable_2) begin
          next_prdata = {16'h0000, enable_2};
        end else begin
          next_prdata = 32'h0000_0000;
        end
      end
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ack <= 1'b0;
      bad <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      ack <= next_ack;
      bad <= next_bad;
      prdata <= next_prdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flag registers.

  irq_flag_word #(.IMPL_MASK(IMPL_MASK_0)) flags_word_0 (
    .ref_clk(ref_clk),
    .reset(reset),
    .set_pulse(src_req_0),
    .wr_en(wr_done && hit_flags_0),
    .wr_data(pwdata[15:0]),
    .flags(irq_flags_0)
  );

  irq_flag_word #(.IMPL_MASK(IMPL_MASK_1)) flags_word_1 (
    .ref_clk(ref_clk),
    .reset(reset),
    .set_pulse(src_req_1),
    .wr_en(wr_done && hit_flags_1),
    .wr_data(pwdata[15:0]),
    .flags(irq_flags_1)
  );

  irq_flag_word #(.IMPL_MASK(IMPL_MASK_2)) flags_word_2 (
    .ref_clk(ref_clk),
    .reset(reset),
    .set_pulse(src_req_2),
    .wr_en(wr_done && hit_flags_2),
    .wr_data(pwdata[15:0]),
    .flags(irq_flags_2)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Enable registers and the interrupt line.

  logic [15:0] next_enable_0;
  logic [15:0] next_enable_1;
  logic [15:0] next_enable_2;

  always_comb begin
    next_enable_0 = enable_0;
    next_enable_1 = enable_1;
    next_enable_2 = enable_2;
    if (wr_done && hit_enable_0) begin
      next_enable_0 = pwdata[15:0] & IMPL_MASK_0;
    end
    if (wr_done && hit_enable_1) begin
      next_enable_1 = pwdata[15:0] & IMPL_MASK_1;
    end
    if (wr_done && hit_enable_2) begin
      next_enable_2 = pwdata[15:0] & IMPL_MASK_2;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      enable_0 <= ENABLE_RESET;
      enable_1 <= ENABLE_RESET;
      enable_2 <= ENABLE_RESET;
    end else begin
      enable_0 <= next_enable_0;
      enable_1 <= next_enable_1;
      enable_2 <= next_enable_2;
    end
  end

  // A request is forwarded only where its enable bit is one.
  assign pending_0 = irq_flags_0 & enable_0;
  assign pending_1 = irq_flags_1 & enable_1;
  assign pending_2 = irq_flags_2 & enable_2;
  assign irq = |{pending_0, pending_1, pending_2};

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  sequence bus_setup_s;
    psel && !penable;
  endsequence

  sequence bus_wait_s;
    psel && penable && !pready;
  endsequence

  sequence bus_done_s;
    psel && penable && pready;
  endsequence

  bus_wait_state_a: assert property (@(posedge ref_clk) disable iff (reset)
    bus_setup_s ##1 (psel && penable) |-> bus_wait_s ##1 bus_done_s)
    else $error("access phase did not take one wait state");

  unmapped_error_a: assert property (@(posedge ref_clk) disable iff (reset)
    bus_done_s and !mapped |-> pslverr && (prdata == 32'h0000_0000))
    else $error("unmapped address not refused");

  read_back_a: assert property (@(posedge ref_clk) disable iff (reset)
    bus_done_s and (!pwrite && hit_flags_2) |-> prdata == {16'h0000, $past(irq_flags_2)})
    else $error("flag read returned wrong value");

  reserved_read_a: assert property (@(posedge ref_clk) disable iff (reset)
    bus_done_s and (!pwrite && (hit_flags_0 || hit_flags_1 || hit_flags_2))
      |-> !prdata[15] || !hit_flags_0 ##0 (!prdata[2] || !hit_flags_1) ##0 (!prdata[13] || !hit_flags_2))
    else $error("reserved flag bit read as one");

  reset_clear_a: assert property (@(posedge ref_clk)
    reset |-> (irq_flags_0 == 16'h0000) && (irq_flags_1 == 16'h0000) && (irq_flags_2 == 16'h0000))
    else $error("flags not clear during reset");

  write_update_a: assert property (@(posedge ref_clk) disable iff (reset)
    wr_done && hit_flags_1 && (src_req_1 == 16'h0000) |=> irq_flags_1 == ($past(pwdata[15:0]) & IMPL_MASK_1))
    else $error("flag write did not store");

  map_upper_0_a: assert property (@(posedge ref_clk) disable iff (reset)
    src_req_0[DMA_CH1_DONE_FLAG] && src_req_0[SPI_A_FAULT_FLAG] |=> irq_flags_0[14] && irq_flags_0[9])
    else $error("first register upper field misplaced");

  map_lower_0_a: assert property (@(posedge ref_clk) disable iff (reset)
    src_req_0[DMA_CH0_DONE_FLAG] && src_req_0[EXT_PIN_A_FLAG] |=> irq_flags_0[4] && irq_flags_0[0])
    else $error("first register lower field misplaced");

  map_upper_1_a: assert property (@(posedge ref_clk) disable iff (reset)
    src_req_1[UART_B_TX_FLAG] && src_req_1[DMA_CH2_DONE_FLAG] |=> irq_flags_1[15] && irq_flags_1[8])
    else $error("second register upper field misplaced");

  map_lower_1_a: assert property (@(posedge ref_clk) disable iff (reset)
    src_req_1[PIN_CHANGE_FLAG] && src_req_1[TWOWIRE_A_MASTER_FLAG] |=> irq_flags_1[3] && irq_flags_1[1])
    else $error("second register lower field misplaced");

  map_upper_2_a: assert property (@(posedge ref_clk) disable iff (reset)
    src_req_2[TIMER_F_FLAG] && src_req_2[DMA_CH4_DONE_FLAG] |=> irq_flags_2[15] && irq_flags_2[14])
    else $error("third register upper field misplaced");

  map_lower_2_a: assert property (@(posedge ref_clk) disable iff (reset)
    src_req_2[CAN_A_RX_READY_FLAG] && src_req_2[SPI_B_ERROR_FLAG] |=> irq_flags_2[2] && irq_flags_2[0])
    else $error("third register lower field misplaced");

  set_wins_a: assert property (@(posedge ref_clk) disable iff (reset)
    wr_done && hit_flags_0 && (pwdata[15:0] == 16'h0000) && src_req_0[TIMER_A_FLAG]
      |=> irq_flags_0 == ($past(src_req_0) & IMPL_MASK_0))
    else $error("set lost against a clearing write");

  enable_gate_a: assert property (@(posedge ref_clk) disable iff (reset)
    (enable_1 == 16'h0000) && (enable_0 == 16'h0000) && (enable_2 == 16'h0000)
      && !(wr_done && (hit_enable_0 || hit_enable_1 || hit_enable_2)) |=> !irq)
    else $error("interrupt raised with all enables off");

  irq_follow_a: assert property (@(posedge ref_clk) disable iff (reset)
    enable_2[SPI_B_EVENT_FLAG] && src_req_2[SPI_B_EVENT_FLAG] && !(wr_done && hit_enable_2)
      |=> irq && pending_2[SPI_B_EVENT_FLAG])
    else $error("enabled request not forwarded");

  // The bus answer lasts one cycle and an error only marks a completed unmapped access.
  pready_pulse_a: assert property (@(posedge ref_clk) disable iff (reset)
    pready |=> !pready)
    else $error("pready held longer than one cycle");

  error_done_a: assert property (@(posedge ref_clk) disable iff (reset)
    pslverr |-> pready && !mapped)
    else $error("error response outside an unmapped completion");

  upper_zero_a: assert property (@(posedge ref_clk) disable iff (reset)
    prdata[31:16] == 16'h0000)
    else $error("upper read half not zero");

  enable_reserved_a: assert property (@(posedge ref_clk) disable iff (reset)
    ((enable_0 & ~IMPL_MASK_0) | (enable_1 & ~IMPL_MASK_1) | (enable_2 & ~IMPL_MASK_2)) == 16'h0000)
    else $error("reserved enable bit set");

  // Stored state moves only on a completed write or a source pulse.
  write_lands_0_a: assert property (@(posedge ref_clk) disable iff (reset)
    wr_done && hit_flags_0 && (src_req_0 == 16'h0000) |=> irq_flags_0 == ($past(pwdata[15:0]) & IMPL_MASK_0))
    else $error("first flag write did not store");

  write_lands_2_a: assert property (@(posedge ref_clk) disable iff (reset)
    wr_done && hit_flags_2 && (src_req_2 == 16'h0000) |=> irq_flags_2 == ($past(pwdata[15:0]) & IMPL_MASK_2))
    else $error("third flag write did not store");

  flag_steady_a: assert property (@(posedge ref_clk) disable iff (reset)
    !wr_done && (src_req_1 == 16'h0000) |=> irq_flags_1 == $past(irq_flags_1))
    else $error("flag changed without write or request");

  enable_write_a: assert property (@(posedge ref_clk) disable iff (reset)
    wr_done && hit_enable_0 |=> enable_0 == ($past(pwdata[15:0]) & IMPL_MASK_0))
    else $error("enable write did not store");

  enable_read_a: assert property (@(posedge ref_clk) disable iff (reset)
    bus_done_s and (!pwrite && hit_enable_1) |-> prdata == {16'h0000, $past(enable_1)})
    else $error("enable read returned wrong value");

  flag_read_a: assert property (@(posedge ref_clk) disable iff (reset)
    bus_done_s and (!pwrite && hit_flags_0) |-> prdata == {16'h0000, $past(irq_flags_0)})
    else $error("first flag read returned wrong value");

endmodule
`default_nettype wire

//--- hw/irq_flag_word.sv
// One 16-bit interrupt flag register with hardware set and software write.
`timescale 1ns/1ps
`default_nettype none
module irq_flag_word
  import irq_flag_pkg::*;
#(
  parameter logic [15:0] IMPL_MASK = 16'hFFFF
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [15:0] set_pulse,
  input wire logic wr_en,
  input wire logic [15:0] wr_data,
  output logic [15:0] flags
);

  logic [15:0] next_flags;

  // A set pulse is ORed after the write, so it survives a clearing write.
  always_comb begin
    next_flags = wr_en ? wr_data : flags;
    next_flags = (next_flags | set_pulse) & IMPL_MASK;
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      flags <= FLAGS_RESET;
    end else begin
      flags <= next_flags;
    end
  end

  reserved_zero_a: assert property (@(posedge ref_clk) disable iff (reset)
    (flags & ~IMPL_MASK) == 16'h0000)
    else $error("reserved flag bit set");

  set_hold_a: assert property (@(posedge ref_clk) disable iff (reset)
    (flags != 16'h0000) && !wr_en |=> ((flags & $past(flags)) == $past(flags)))
    else $error("flag lost without a write");

endmodule
`default_nettype wire

//--- shared/irq_flag_pkg.sv
// Register map, field positions and reset values of the interrupt flag bank.
package irq_flag_pkg;

  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned FLAG_W = 16;

  // Byte addresses of the bus registers.
  localparam logic [11:0] OFF_IRQ_FLAGS_0 = 12'h000;
  localparam logic [11:0] OFF_IRQ_FLAGS_1 = 12'h004;
  localparam logic [11:0] OFF_IRQ_FLAGS_2 = 12'h008;
  localparam logic [11:0] OFF_IRQ_ENABLE_0 = 12'h00C;
  localparam logic [11:0] OFF_IRQ_ENABLE_1 = 12'h010;
  localparam logic [11:0] OFF_IRQ_ENABLE_2 = 12'h014;

  // Implemented flag positions; a zero marks a reserved bit.
  localparam logic [15:0] IMPL_MASK_0 = 16'h7FFF;
  localparam logic [15:0] IMPL_MASK_1 = 16'hFFFB;
  localparam logic [15:0] IMPL_MASK_2 = 16'hDFFF;

  localparam logic [15:0] FLAGS_RESET = 16'h0000;
  localparam logic [15:0] ENABLE_RESET = 16'h0000;

  // Fields of irq_flags_0.
  localparam int unsigned DMA_CH1_DONE_FLAG = 14;
  localparam int unsigned ADC_A_DONE_FLAG = 13;
  localparam int unsigned UART_A_TX_FLAG = 12;
  localparam int unsigned UART_A_RX_FLAG = 11;
  localparam int unsigned SPI_A_EVENT_FLAG = 10;
  localparam int unsigned SPI_A_FAULT_FLAG = 9;
  localparam int unsigned TIMER_C_FLAG = 8;
  localparam int unsigned TIMER_B_FLAG = 7;
  localparam int unsigned COMPARE_B_FLAG = 6;
  localparam int unsigned CAPTURE_B_FLAG = 5;
  localparam int unsigned DMA_CH0_DONE_FLAG = 4;
  localparam int unsigned TIMER_A_FLAG = 3;
  localparam int unsigned COMPARE_A_FLAG = 2;
  localparam int unsigned CAPTURE_A_FLAG = 1;
  localparam int unsigned EXT_PIN_A_FLAG = 0;

  // Fields of irq_flags_1.
  localparam int unsigned UART_B_TX_FLAG = 15;
  localparam int unsigned UART_B_RX_FLAG = 14;
  localparam int unsigned EXT_PIN_C_FLAG = 13;
  localparam int unsigned TIMER_E_FLAG = 12;
  localparam int unsigned TIMER_D_FLAG = 11;
  localparam int unsigned COMPARE_D_FLAG = 10;
  localparam int unsigned COMPARE_C_FLAG = 9;
  localparam int unsigned DMA_CH2_DONE_FLAG = 8;
  localparam int unsigned CAPTURE_H_FLAG = 7;
  localparam int unsigned CAPTURE_G_FLAG = 6;
  localparam int unsigned ADC_B_DONE_FLAG = 5;
  localparam int unsigned EXT_PIN_B_FLAG = 4;
  localparam int unsigned PIN_CHANGE_FLAG = 3;
  localparam int unsigned TWOWIRE_A_MASTER_FLAG = 1;
  localparam int unsigned TWOWIRE_A_SLAVE_FLAG = 0;

  // Fields of irq_flags_2.
  localparam int unsigned TIMER_F_FLAG = 15;
  localparam int unsigned DMA_CH4_DONE_FLAG = 14;
  localparam int unsigned COMPARE_H_FLAG = 12;
  localparam int unsigned COMPARE_G_FLAG = 11;
  localparam int unsigned COMPARE_F_FLAG = 10;
  localparam int unsigned COMPARE_E_FLAG = 9;
  localparam int unsigned CAPTURE_F_FLAG = 8;
  localparam int unsigned CAPTURE_E_FLAG = 7;
  localparam int unsigned CAPTURE_D_FLAG = 6;
  localparam int unsigned CAPTURE_C_FLAG = 5;
  localparam int unsigned DMA_CH3_DONE_FLAG = 4;
  localparam int unsigned CAN_A_EVENT_FLAG = 3;
  localparam int unsigned CAN_A_RX_READY_FLAG = 2;
  localparam int unsigned SPI_B_EVENT_FLAG = 1;
  localparam int unsigned SPI_B_ERROR_FLAG = 0;

endpackage

//--- tb/event_source_model.sv
// Model of the on-chip event sources that raise requests into the flag bank.
`timescale 1ns/1ps
`default_nettype none
module event_source_model (
  input wire logic go,
  input wire logic [1:0] sel,
  input wire logic [15:0] bits,
  output logic [15:0] src_req_0,
  output logic [15:0] src_req_1,
  output logic [15:0] src_req_2
);
  // A command held for one cycle is a one-cycle pulse; a held command keeps requesting.
  always_comb begin
    src_req_0 = (go && sel == 2'h0) ? bits : 16'h0000;
    src_req_1 = (go && sel == 2'h1) ? bits : 16'h0000;
    src_req_2 = (go && sel == 2'h2) ? bits : 16'h0000;
  end
endmodule
`default_nettype wire

//--- tb/testbench.sv
// Self-checking testbench for the interrupt flag status bank.
`timescale 1ns/1ps
`default_nettype none
module testbench
  import irq_flag_pkg::*;
;
  typedef struct packed {logic [11:0] a; logic [15:0] m; logic err;} row_t;
  localparam row_t ROWS [8] = '{'{OFF_IRQ_FLAGS_0, IMPL_MASK_0, 1'h0}, '{OFF_IRQ_FLAGS_1, IMPL_MASK_1, 1'h0},
    '{OFF_IRQ_FLAGS_2, IMPL_MASK_2, 1'h0}, '{OFF_IRQ_ENABLE_0, IMPL_MASK_0, 1'h0},
    '{OFF_IRQ_ENABLE_1, IMPL_MASK_1, 1'h0}, '{OFF_IRQ_ENABLE_2, IMPL_MASK_2, 1'h0},
    '{12'h018, 16'h0000, 1'h1}, '{12'hFFC, 16'h0000, 1'h1}};
  localparam logic [15:0] MK [3] = '{IMPL_MASK_0, IMPL_MASK_1, IMPL_MASK_2};
  localparam logic [11:0] FOFF [3] = '{OFF_IRQ_FLAGS_0, OFF_IRQ_FLAGS_1, OFF_IRQ_FLAGS_2};
  logic ref_clk = 1'h0, reset = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, irq, er, go = 1'h0;
  logic [1:0] sel = 2'h0;
  logic [15:0] bits = 16'h0000;
  logic [15:0] src_req_0, src_req_1, src_req_2, irq_flags_0, irq_flags_1, irq_flags_2;
  logic [15:0] pending_0, pending_1, pending_2;
  logic [15:0] fl [3];
  int err_count = 0;
  int comparisons = 0;
  always_comb fl = '{irq_flags_0, irq_flags_1, irq_flags_2};
  always #4 ref_clk = ~ref_clk;
  interrupt_flag_status_bank dut (.ref_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .src_req_0, .src_req_1, .src_req_2, .irq_flags_0, .irq_flags_1, .irq_flags_2, .pending_0,
    .pending_1, .pending_2, .irq);
  event_source_model sources (.go, .sel, .bits, .src_req_0, .src_req_1, .src_req_2);
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_bit(input string nm, input logic e, input logic g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic end_sim;
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // One APB transfer; the request holds until pready is sampled high, and the answer is taken at that edge.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'h1;
    @(posedge ref_clk);
    while (pready !== 1'h1 && n < 50) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 50) begin
      err_count++;
      $display("[FAIL] pready expected 1 seen %b", pready);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // One-cycle request pulse, then settle one edge after it.
  task automatic pulse(input int r, input logic [15:0] v);
    @(posedge ref_clk);
    go <= 1'h1;
    sel <= 2'(r);
    bits <= v;
    @(posedge ref_clk);
    go <= 1'h0;
    @(posedge ref_clk);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    err_count++;
    end_sim();
  end
  initial begin
    reset <= 1'h1;
    repeat (4) @(posedge ref_clk);
    reset <= 1'h0;
    chk_bit("irq after reset", 1'h0, irq);
    for (int i = 0; i < 6; i++) begin
      apb(1'h0, 12'(i * 4), 32'h0, rd, er);
      chk_word("reset value", 32'h0, rd);
    end
    for (int p = 0; p < 2; p++) begin
      for (int k = 0; k < 8; k++) begin
        apb(1'h1, ROWS[k].a, p == 0 ? 32'hFFFFFFFF : 32'h0, rd, er);
        chk_bit("write response", ROWS[k].err, er);
        apb(1'h0, ROWS[k].a, 32'h0, rd, er);
        chk_bit("read response", ROWS[k].err, er);
        chk_word("readback", {16'h0000, p == 0 ? ROWS[k].m : 16'h0000}, rd);
      end
    end
    for (int r = 0; r < 3; r++) begin
      for (int b = 0; b < 16; b++) begin
        pulse(r, 16'h0001 << b);
        chk_word("flag output", {16'h0000, MK[r] & (16'h0001 << b)}, {16'h0000, fl[r]});
        apb(1'h0, FOFF[r], 32'h0, rd, er);
        chk_word("flag read", {16'h0000, MK[r] & (16'h0001 << b)}, rd);
        apb(1'h1, FOFF[r], 32'h0, rd, er);
        #1;
        chk_word("flag cleared", 32'h0, {16'h0000, fl[r]});
      end
    end
    for (int r = 0; r < 3; r++) begin
      pulse(r, 16'hFFFF);
      chk_word("all set", {16'h0000, MK[r]}, {16'h0000, fl[r]});
      apb(1'h1, FOFF[r], 32'h0, rd, er);
    end
    // Sources request through the whole clearing write, so the set must win.
    @(posedge ref_clk);
    go <= 1'h1;
    sel <= 2'h0;
    bits <= 16'hFFFF;
    apb(1'h1, OFF_IRQ_FLAGS_0, 32'h0, rd, er);
    go <= 1'h0;
    #1;
    chk_word("set beats clear", {16'h0000, IMPL_MASK_0}, {16'h0000, irq_flags_0});
    apb(1'h1, OFF_IRQ_FLAGS_0, 32'h0, rd, er);
    pulse(1, 16'h0001 << EXT_PIN_B_FLAG);
    chk_bit("irq masked", 1'h0, irq);
    chk_word("pending masked", 32'h0, {16'h0000, pending_1});
    apb(1'h1, OFF_IRQ_ENABLE_1, 32'h1 << EXT_PIN_B_FLAG, rd, er);
    #1;
    chk_bit("irq enabled", 1'h1, irq);
    chk_word("pending enabled", 32'h1 << EXT_PIN_B_FLAG, {16'h0000, pending_1});
    pulse(2, 16'h0001 << CAN_A_EVENT_FLAG);
    chk_word("pending other", 32'h0, {16'h0000, pending_2});
    apb(1'h1, OFF_IRQ_FLAGS_1, 32'h0, rd, er);
    #1;
    chk_bit("irq cleared", 1'h0, irq);
    apb(1'h1, OFF_IRQ_ENABLE_2, 32'h1 << SPI_B_EVENT_FLAG, rd, er);
    pulse(2, 16'h0001 << SPI_B_EVENT_FLAG);
    chk_word("pending forwarded", 32'h1 << SPI_B_EVENT_FLAG, {16'h0000, pending_2});
    chk_bit("irq forwarded", 1'h1, irq);
    // A second reset in mid-run must clear flags and enables alike.
    apb(1'h1, OFF_IRQ_FLAGS_2, 32'hFFFF, rd, er);
    @(posedge ref_clk);
    reset <= 1'h1;
    @(posedge ref_clk);
    #1;
    chk_word("flags in reset", 32'h0, {16'h0000, irq_flags_2});
    chk_bit("irq in reset", 1'h0, irq);
    @(posedge ref_clk);
    reset <= 1'h0;
    apb(1'h0, OFF_IRQ_ENABLE_1, 32'h0, rd, er);
    chk_word("enable after reset", 32'h0, rd);
    end_sim();
  end
endmodule
`default_nettype wire
